// ===== rtl/mma_pkg.sv
// package: constants for the memory map and eeprom access block
package mma_pkg;
  // variant select: 0 smallest, 1 middle, 2 largest
  localparam int unsigned VARIANT       = 2;
  // program flash depth in 16-bit words per variant
  localparam int unsigned FLASH_WORDS_0 = 2048;
  localparam int unsigned FLASH_WORDS_1 = 4096;
  localparam int unsigned FLASH_WORDS_2 = 8192;
  localparam int unsigned FLASH_WORDS   = (VARIANT == 0) ? FLASH_WORDS_0 :
                                          (VARIANT == 1) ? FLASH_WORDS_1 :
                                          FLASH_WORDS_2;
  localparam int unsigned FLASH_DW      = 16;
  localparam int unsigned PC_W          = $clog2(FLASH_WORDS);
  // data space layout
  localparam int unsigned DA_W          = 16;
  localparam logic [15:0] REG_BASE      = 16'h0000;
  localparam logic [15:0] IO_BASE       = 16'h0020;
  localparam logic [15:0] XIO_BASE      = 16'h0060;
  localparam logic [15:0] SRAM_BASE     = 16'h0100;
  localparam logic [15:0] IO_OFFSET     = 16'h0020;
  localparam int unsigned SRAM_BYTES_0  = 512;
  localparam int unsigned SRAM_BYTES_1  = 1024;
  localparam int unsigned SRAM_BYTES    = (VARIANT == 0) ? SRAM_BYTES_0 :
                                          SRAM_BYTES_1;
  localparam logic [15:0] DATA_END      = 16'(256 + SRAM_BYTES);
  localparam int unsigned SRAM_AW       = $clog2(SRAM_BYTES);
  localparam int unsigned DISP_MAX      = 63;
  // eeprom
  localparam int unsigned EE_BYTES_0    = 256;
  localparam int unsigned EE_BYTES_1    = 512;
  localparam int unsigned EE_BYTES      = (VARIANT == 0) ? EE_BYTES_0 :
                                          EE_BYTES_1;
  localparam int unsigned EE_AW         = 9;
  // eeprom register i/o addresses (short form)
  localparam logic [5:0]  IOA_EECR      = 6'h1F;
  localparam logic [5:0]  IOA_EEDR      = 6'h20;
  localparam logic [5:0]  IOA_EEARL     = 6'h21;
  localparam logic [5:0]  IOA_EEARH     = 6'h22;
  // control register field positions
  localparam int unsigned B_RD          = 0;
  localparam int unsigned B_STROBE      = 1;
  localparam int unsigned B_ARM         = 2;
  localparam int unsigned B_RIE         = 3;
  localparam int unsigned B_PM_LO       = 4;
  localparam int unsigned B_PM_HI       = 5;
  // timing
  localparam int unsigned CLK_MHZ       = 100;
  localparam int unsigned ARM_CYC       = 4;
  localparam int unsigned RD_STALL_CYC  = 4;
  localparam int unsigned WR_STALL_CYC  = 2;
  localparam int unsigned SRAM_CYC      = 2;
  localparam int unsigned T_ATOMIC_US10 = 34;
  localparam int unsigned T_SPLIT_US10  = 18;
  localparam int unsigned ATOMIC_CYC    = T_ATOMIC_US10 * 100 * CLK_MHZ;
  localparam int unsigned SPLIT_CYC     = T_SPLIT_US10 * 100 * CLK_MHZ;
  // pointer addressing modes
  typedef enum logic [2:0] {
    AM_DIRECT = 3'b000,
    AM_IND    = 3'b001,
    AM_DISP   = 3'b010,
    AM_PREDEC = 3'b011,
    AM_POSTIN = 3'b100
  } mma_amode_t;
  // decoded target region
  typedef enum logic [2:0] {
    RG_REGS = 3'b000,
    RG_IO   = 3'b001,
    RG_XIO  = 3'b010,
    RG_SRAM = 3'b011,
    RG_NONE = 3'b100
  } mma_region_t;
  // eeprom controller states
  typedef enum logic [1:0] {
    EE_IDLE  = 2'b00,
    EE_RSTL  = 2'b01,
    EE_WSTL  = 2'b10,
    EE_PROG  = 2'b11
  } mma_eest_t;
endpackage

// ===== rtl/mma_sram.sv
// file: internal data sram with two-cycle access
`timescale 1ns/100ps
module mma_sram
  import mma_pkg::*;
(
  input  wire logic               i_clock,
  input  wire logic               i_arst_n,
  input  wire logic               i_req,
  input  wire logic               i_we,
  input  wire logic [SRAM_AW-1:0] i_addr,
  input  wire logic [7:0]         i_wdata,
  output logic      [7:0]         o_rdata,
  output logic                    o_done
);
  logic [7:0]         mem_r [SRAM_BYTES];   // flip-flop storage
  logic [7:0]         rdata_r;              // read data register
  logic [7:0]         rdata_nxt;
  logic               busy_r;               // second cycle marker
  logic               busy_nxt;
  logic [SRAM_AW-1:0] addr_r;               // address latched cycle 1
  logic [SRAM_AW-1:0] addr_nxt;
  logic               we_r;
  logic               we_nxt;
  logic [7:0]         wd_r;
  logic [7:0]         wd_nxt;

  // cycle one latches and reads the array, cycle two does the array write
  always_comb begin
    busy_nxt  = i_req & ~busy_r;
    addr_nxt  = i_req ? i_addr : addr_r;
    we_nxt    = i_req ? i_we : we_r;
    wd_nxt    = i_req ? i_wdata : wd_r;
    // read in cycle one so the word stands when done is shown
    rdata_nxt = (i_req && !i_we) ? mem_r[i_addr] : rdata_r;
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      busy_r  <= 1'b0;
      addr_r  <= '0;
      we_r    <= 1'b0;
      wd_r    <= 8'h00;
      rdata_r <= 8'h00;
    end else begin
      busy_r  <= busy_nxt;
      addr_r  <= addr_nxt;
      we_r    <= we_nxt;
      wd_r    <= wd_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // array has no reset; contents are undefined at power up
  genvar g;
  generate
    for (g = 0; g < SRAM_BYTES; g++) begin : g_cell
      always_ff @(posedge i_clock) begin
        if (busy_r && we_r && addr_r == g) begin
          mem_r[g] <= wd_r;
        end
      end
    end
  endgenerate

  assign o_rdata = rdata_r;
  assign o_done  = busy_r;         // access ends on second cycle
endmodule

// ===== rtl/mma_eeprom.sv
// file: eeprom byte array written or read by the controller
`timescale 1ns/100ps
module mma_eeprom
  import mma_pkg::*;
(
  input  wire logic             i_clock,
  input  wire logic             i_rd,
  input  wire logic             i_erase,
  input  wire logic             i_write,
  input  wire logic [EE_AW-1:0] i_addr,
  input  wire logic [7:0]       i_wdata,
  output logic      [7:0]       o_rdata
);
  logic [7:0] cell_r [EE_BYTES];  // non-volatile cells, no reset
  logic [7:0] rd_r;

  // erase sets 0xFF; write-only can only clear bits
  genvar g;
  generate
    for (g = 0; g < EE_BYTES; g++) begin : g_cell
      always_ff @(posedge i_clock) begin
        if (i_addr == g) begin
          if (i_erase && i_write) begin
            cell_r[g] <= i_wdata;
          end else if (i_erase) begin
            cell_r[g] <= 8'hFF;
          end else if (i_write) begin
            cell_r[g] <= cell_r[g] & i_wdata;
          end
        end
      end
    end
  endgenerate

  // read port, registered; no reset needed for a data path
  always_ff @(posedge i_clock) begin
    if (i_rd) begin
      rd_r <= cell_r[i_addr];
    end
  end
  assign o_rdata = rd_r;
endmodule

// ===== rtl/mma_top.sv
// file: data space decoder, pointer logic and eeprom controller
`timescale 1ns/100ps
// Overview of operation
// - flash is 16-bit words, 2K/4K/8K deep
// - program counter 11/12/13 bits per variant
// - smallest variant: no boot split, store anywhere
// - data addresses 0..31 are working registers
// - next 64 addresses are standard i/o
// - 0x60..0xFF are 160 extended i/o locations
// - short i/o form cannot reach extended i/o
// - sram follows, 512/1024/1024 locations
// - direct addressing reaches whole data space
// - displacement up to 63 added to Y/Z
// - R26..R31 hold the X, Y, Z pointers
// - predecrement before, postincrement after the access
// - sram access takes exactly two cycles
// - eeprom is separate byte space 256/512/512
// - eeprom registers live in i/o space
// - self-timed write with readable done indication
// - write only after unlock, else rejected
// - eeprom read halts cpu four cycles
// - eeprom write halts cpu two cycles
// - arm expires four cycles after set
// - mode 00 atomic, 01 erase, 10 write
// - ready irq while strobe clear, not busy
// - short i/o address plus 0x20 in data space
module mma_top
  import mma_pkg::*;
#(
  parameter int unsigned ATOMIC_CYCLES = ATOMIC_CYC,
  parameter int unsigned SPLIT_CYCLES  = SPLIT_CYC
) (
  input  wire logic            i_clock,
  input  wire logic            i_arst_n,
  input  wire logic            i_req,        // cpu data access
  input  wire logic            i_we,
  input  wire logic            i_short_io,   // in/out form, 6-bit addr
  input  wire logic [2:0]      i_amode,
  input  wire logic [1:0]      i_ptr_sel,    // 0 X, 1 Y, 2 Z
  input  wire logic [5:0]      i_disp,
  input  wire logic [15:0]     i_addr,
  input  wire logic [7:0]      i_wdata,
  input  wire logic            i_flash_selfwrite_active,
  input  wire logic            i_global_irq_en,
  output logic      [7:0]      o_rdata,
  output logic                 o_ready,      // access done this cycle
  output logic                 o_stall,      // cpu halt
  output logic      [15:0]     o_eff_addr,
  output logic      [2:0]      o_region,
  output logic      [PC_W-1:0] o_program_counter_max,
  output logic                 o_boot_split,
  output logic                 o_eeprom_busy,
  output logic                 o_eeprom_ready_irq
);
  // working register file; R26..R31 double as pointers
  logic [7:0]  gpr_r [32];
  logic [7:0]  gpr_nxt [32];
  logic [7:0]  io_r [64];        // standard i/o backing store
  logic [7:0]  io_nxt [64];
  logic [7:0]  xio_r [160];      // extended i/o backing store
  logic [7:0]  xio_nxt [160];
  logic [15:0] ptr;              // selected pointer value
  logic [15:0] ea;               // effective data address
  mma_region_t rg;
  logic [7:0]  rd_mux;
  logic        sram_req;
  logic        sram_done;
  logic [7:0]  sram_rd;
  logic [7:0]  rdata_r;
  logic [7:0]  rdata_nxt;

  // eeprom controller state
  mma_eest_t         st_r, st_nxt;
  logic [31:0]       cnt_r, cnt_nxt;
  logic [EE_AW-1:0]  eear_r, eear_nxt;
  logic [7:0]        eedr_r, eedr_nxt;
  logic [1:0]        pm_r, pm_nxt;
  logic              rie_r, rie_nxt;
  logic              arm_r, arm_nxt;
  logic [2:0]        armc_r, armc_nxt;
  logic              strobe_r, strobe_nxt;
  logic              ee_rd, ee_er, ee_wr;
  logic [7:0]        ee_q;
  logic              io_wr;
  logic [5:0]        ioa;

  // flash shape is fixed per variant; store allowed everywhere on small
  assign o_program_counter_max = PC_W'(FLASH_WORDS - 1);
  assign o_boot_split = (VARIANT != 0);

  // pointer select from the top six working registers
  always_comb begin
    case (i_ptr_sel)
      2'd0:    ptr = {gpr_r[27], gpr_r[26]};
      2'd1:    ptr = {gpr_r[29], gpr_r[28]};
      default: ptr = {gpr_r[31], gpr_r[30]};
    endcase
  end

  // effective address per addressing mode
  always_comb begin
    if (i_short_io) begin
      ea = {10'h000, i_addr[5:0]} + IO_OFFSET;
    end else begin
      case (mma_amode_t'(i_amode))
        AM_DIRECT: ea = i_addr;
        AM_DISP:   ea = ptr + {10'h000, i_disp};
        AM_PREDEC: ea = ptr - 16'h0001;
        default:   ea = ptr;
      endcase
    end
  end

  // region decode of the lower data space
  always_comb begin
    if (ea < IO_BASE)        rg = RG_REGS;
    else if (ea < XIO_BASE)  rg = RG_IO;
    else if (ea < SRAM_BASE) rg = RG_XIO;
    else if (ea < DATA_END)  rg = RG_SRAM;
    else                     rg = RG_NONE;
  end
  assign ioa       = 6'(ea - IO_BASE);
  assign io_wr     = i_req & i_we & (rg == RG_IO) & ~o_stall;
  assign sram_req  = i_req & (rg == RG_SRAM) & ~sram_done & ~o_stall;

  mma_sram u_sram (
    .i_clock (i_clock),
    .i_arst_n(i_arst_n),
    .i_req   (sram_req),
    .i_we    (i_we),
    .i_addr  (SRAM_AW'(ea - SRAM_BASE)),
    .i_wdata (i_wdata),
    .o_rdata (sram_rd),
    .o_done  (sram_done)
  );

  // read mux; eeprom registers overlay standard i/o
  always_comb begin
    rd_mux = 8'h00;
    case (rg)
      RG_REGS: rd_mux = gpr_r[ea[4:0]];
      RG_IO: begin
        case (ioa)
          IOA_EECR:  rd_mux = {2'b00, pm_r, rie_r, arm_r, strobe_r, 1'b0};
          IOA_EEDR:  rd_mux = eedr_r;
          IOA_EEARL: rd_mux = eear_r[7:0];
          IOA_EEARH: rd_mux = {7'h00, eear_r[8]};
          default:   rd_mux = io_r[ioa];
        endcase
      end
      RG_XIO:  rd_mux = xio_r[8'(ea - XIO_BASE)];
      default: rd_mux = 8'h00;
    endcase
  end

  // register file, i/o stores and pointer update
  always_comb begin
    gpr_nxt   = gpr_r;
    io_nxt    = io_r;
    xio_nxt   = xio_r;
    rdata_nxt = rdata_r;
    if (i_req && !o_stall && rg != RG_SRAM) begin
      rdata_nxt = rd_mux;
      if (i_we && rg == RG_REGS) gpr_nxt[ea[4:0]] = i_wdata;
      if (io_wr) io_nxt[ioa] = i_wdata;
      if (i_we && rg == RG_XIO) xio_nxt[8'(ea - XIO_BASE)] = i_wdata;
    end
    if (sram_done) rdata_nxt = sram_rd;
    // pointer written back once the access is done
    if (o_ready && !i_short_io) begin
      if (mma_amode_t'(i_amode) == AM_PREDEC ||
          mma_amode_t'(i_amode) == AM_POSTIN) begin
        // pointer pairs start at R26, two registers apart
        {gpr_nxt[5'd27 + 5'({i_ptr_sel, 1'b0})],
         gpr_nxt[5'd26 + 5'({i_ptr_sel, 1'b0})]} = ea +
          ((mma_amode_t'(i_amode) == AM_POSTIN) ? 16'h0001 : 16'h0000);
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      gpr_r   <= '{default: 8'h00};
      io_r    <= '{default: 8'h00};
      xio_r   <= '{default: 8'h00};
      rdata_r <= 8'h00;
    end else begin
      gpr_r   <= gpr_nxt;
      io_r    <= io_nxt;
      xio_r   <= xio_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // eeprom control: unlock window, stalls and self-timed write
  always_comb begin
    st_nxt     = st_r;
    cnt_nxt    = cnt_r;
    eear_nxt   = eear_r;
    eedr_nxt   = eedr_r;
    pm_nxt     = pm_r;
    rie_nxt    = rie_r;
    arm_nxt    = arm_r;
    armc_nxt   = armc_r;
    strobe_nxt = strobe_r;
    ee_rd      = 1'b0;
    ee_er      = 1'b0;
    ee_wr      = 1'b0;
    // arm window runs out after four cycles
    if (arm_r) begin
      if (armc_r == 3'(ARM_CYC - 1)) arm_nxt = 1'b0;
      armc_nxt = armc_r + 3'd1;
    end
    if (io_wr) begin
      case (ioa)
        IOA_EEDR:  eedr_nxt = i_wdata;
        IOA_EEARL: eear_nxt[7:0] = i_wdata;
        IOA_EEARH: eear_nxt[8] = i_wdata[0] & (EE_BYTES > 256);
        IOA_EECR: begin
          rie_nxt = i_wdata[B_RIE];
          if (!strobe_r) pm_nxt = i_wdata[B_PM_HI:B_PM_LO];
          if (i_wdata[B_ARM] && !i_wdata[B_STROBE]) begin
            arm_nxt  = 1'b1;
            armc_nxt = 3'd0;
          end
          // strobe without a live arm starts no write
          if (i_wdata[B_STROBE] && arm_r && !strobe_r &&
              !i_flash_selfwrite_active && st_r == EE_IDLE &&
              pm_r != 2'b11) begin
            strobe_nxt = 1'b1;
            arm_nxt    = 1'b0;
            st_nxt     = EE_WSTL;
            cnt_nxt    = 32'(WR_STALL_CYC - 1);
            ee_er      = (pm_r != 2'b10);
            ee_wr      = (pm_r != 2'b01);
          end else if (i_wdata[B_RD] && !strobe_r) begin
            st_nxt  = EE_RSTL;
            cnt_nxt = 32'(RD_STALL_CYC - 1);
            ee_rd   = 1'b1;
          end
        end
        default: ;
      endcase
    end
    case (st_r)
      EE_RSTL: begin
        if (cnt_r == 32'd0) begin
          st_nxt   = EE_IDLE;
          eedr_nxt = ee_q;
        end else cnt_nxt = cnt_r - 32'd1;
      end
      EE_WSTL: begin
        if (cnt_r == 32'd0) begin
          st_nxt  = EE_PROG;
          cnt_nxt = (pm_r == 2'b00) ? 32'(ATOMIC_CYCLES) :
                    32'(SPLIT_CYCLES);
        end else cnt_nxt = cnt_r - 32'd1;
      end
      EE_PROG: begin
        if (cnt_r == 32'd0) begin
          st_nxt     = EE_IDLE;
          strobe_nxt = 1'b0;
        end else cnt_nxt = cnt_r - 32'd1;
      end
      default: ;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_r     <= EE_IDLE;
      cnt_r    <= 32'd0;
      eear_r   <= '0;
      eedr_r   <= 8'h00;
      pm_r     <= 2'b00;
      rie_r    <= 1'b0;
      arm_r    <= 1'b0;
      armc_r   <= 3'd0;
      strobe_r <= 1'b0;
    end else begin
      st_r     <= st_nxt;
      cnt_r    <= cnt_nxt;
      eear_r   <= eear_nxt;
      eedr_r   <= eedr_nxt;
      pm_r     <= pm_nxt;
      rie_r    <= rie_nxt;
      arm_r    <= arm_nxt;
      armc_r   <= armc_nxt;
      strobe_r <= strobe_nxt;
    end
  end

  mma_eeprom u_eeprom (
    .i_clock(i_clock),
    .i_rd   (ee_rd),
    .i_erase(ee_er),
    .i_write(ee_wr),
    .i_addr (eear_r),
    .i_wdata(eedr_r),
    .o_rdata(ee_q)
  );

  // halt while read or write stall runs
  assign o_stall    = (st_r == EE_RSTL) | (st_r == EE_WSTL);
  assign o_ready    = i_req & ~o_stall & ((rg != RG_SRAM) | sram_done);
  assign o_rdata    = rdata_r;
  assign o_eff_addr = ea;
  assign o_region   = rg;
  assign o_eeprom_busy = strobe_r;
  assign o_eeprom_ready_irq = rie_r & i_global_irq_en & ~strobe_r &
                              ~i_flash_selfwrite_active;
endmodule

// ===== tb/mma_cpu_model.sv
// partner model: cpu core issuing one data access at a time
`timescale 1ns/100ps
module mma_cpu_model
  import mma_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_ready,
  input  wire logic [7:0]  i_rdata,
  input  wire logic [2:0]  i_region,
  input  wire logic [15:0] i_eff_addr,
  output logic             o_req,
  output logic             o_we,
  output logic             o_short_io,
  output logic      [2:0]  o_amode,
  output logic      [1:0]  o_ptr_sel,
  output logic      [5:0]  o_disp,
  output logic      [15:0] o_addr,
  output logic      [7:0]  o_wdata
);
  logic [2:0]  seen_rg;   // region shown in the first cycle
  logic [15:0] seen_ea;   // effective address shown
  int          seen_cyc;  // edges up to and with the ready edge
  // idle bus at time zero
  initial begin
    {o_req, o_we, o_short_io, o_amode, o_ptr_sel, o_disp, o_addr} = '0;
    o_wdata = '0;
  end
  // one access after an idle cycle
  task automatic access(input logic we, sio, input logic [2:0] am,
    input logic [1:0] ps, input logic [5:0] dp, input logic [15:0] a,
    input logic [7:0] wd, output logic [7:0] rd);
    logic rdy;
    seen_cyc = 0;
    @(negedge i_clock);
    {o_req, o_we, o_short_io, o_amode, o_ptr_sel, o_disp, o_addr, o_wdata}
      = {1'b1, we, sio, am, ps, dp, a, wd};
    #1;
    seen_rg = i_region;
    seen_ea = i_eff_addr;
    // hold until ready at a rising edge
    forever begin
      rdy = i_ready;
      seen_cyc++;
      @(posedge i_clock);
      if (rdy === 1'b1 || seen_cyc > 40) break;
      @(negedge i_clock);
    end
    @(negedge i_clock);
    rd = i_rdata;
    // released address and write data lines show inverted values
    o_req = 1'b0;
    o_addr = ~a;
    o_wdata = ~wd;
  endtask
endmodule

// ===== tb/mma_top_assertions.sv
// checker: port-level properties of the memory map block
`timescale 1ns/100ps
module mma_top_assertions
  import mma_pkg::*;
#(
  parameter int unsigned ATOMIC_CYCLES = ATOMIC_CYC
) (
  input wire logic        i_clock,
  input wire logic        i_arst_n,
  input wire logic        i_req,
  input wire logic        i_short_io,
  input wire logic [2:0]  i_amode,
  input wire logic [15:0] i_addr,
  input wire logic        i_flash_selfwrite_active,
  input wire logic        i_global_irq_en,
  input wire logic        o_ready,
  input wire logic        o_stall,
  input wire logic [15:0] o_eff_addr,
  input wire logic [2:0]  o_region,
  input wire logic        o_eeprom_busy,
  input wire logic        o_eeprom_ready_irq
);
  logic [15:0] busy_cnt_r;  // cycles the write strobe has stood
  // grow while busy, clear when idle
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      busy_cnt_r <= 16'h0000;
    end else begin
      busy_cnt_r <= o_eeprom_busy ? busy_cnt_r + 16'h0001 : 16'h0000;
    end
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);
  property p_regs;
    i_req && !i_short_io && i_amode == AM_DIRECT && i_addr < IO_BASE
      |-> o_region == RG_REGS && o_eff_addr == i_addr;
  endproperty
  a_regs: assert property (p_regs) else $error("regs decode");
  property p_xio;
    i_req && !i_short_io && i_amode == AM_DIRECT && i_addr >= XIO_BASE
      && i_addr < SRAM_BASE |-> o_region == RG_XIO;
  endproperty
  a_xio: assert property (p_xio) else $error("xio decode");
  property p_short;
    i_req && i_short_io |-> o_region == RG_IO
      && o_eff_addr == {10'h000, i_addr[5:0]} + IO_OFFSET;
  endproperty
  a_short: assert property (p_short) else $error("short io");
  property p_sram_wait;
    i_req && o_region == RG_SRAM && !o_ready && !o_stall |=> o_ready;
  endproperty
  a_sram_wait: assert property (p_sram_wait) else $error("sram slow");
  property p_sram_first;
    i_req && o_ready && o_region == RG_SRAM
      |-> $past(i_req) && !$past(o_ready);
  endproperty
  a_sram_first: assert property (p_sram_first) else $error("sram fast");
  property p_stall;
    $rose(o_stall) |-> (o_stall[*4] ##1 !o_stall)
      or (o_stall[*2] ##1 !o_stall);
  endproperty
  a_stall: assert property (p_stall) else $error("stall length");
  property p_refuse;
    o_stall |-> !o_ready;
  endproperty
  a_refuse: assert property (p_refuse) else $error("taken in stall");
  property p_irq;
    o_eeprom_busy || i_flash_selfwrite_active || !i_global_irq_en
      |-> !o_eeprom_ready_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq while busy");
  property p_busy_max;
    o_eeprom_busy |-> busy_cnt_r <= ATOMIC_CYCLES + 2;
  endproperty
  a_busy_max: assert property (p_busy_max) else $error("busy long");
  c_sram: cover property (i_req && o_ready && o_region == RG_SRAM);
  c_stall: cover property ($rose(o_stall));
  c_busy: cover property ($fell(o_eeprom_busy));
endmodule
bind mma_top mma_top_assertions #(.ATOMIC_CYCLES(ATOMIC_CYCLES))
  u_mma_top_assertions (
  .i_clock, .i_arst_n, .i_req, .i_short_io, .i_amode, .i_addr,
  .i_flash_selfwrite_active, .i_global_irq_en, .o_ready, .o_stall,
  .o_eff_addr, .o_region, .o_eeprom_busy, .o_eeprom_ready_irq
);

// ===== tb/test_mma_top.sv
// testbench: scenarios for the memory map and eeprom access block
`timescale 1ns/100ps
module test_mma_top
  import mma_pkg::*;
;
  localparam int unsigned AT = 20;  // short atomic program time
  localparam int unsigned SP = 10;  // short split program time
  logic            i_clock;   // 100 MHz core clock
  logic            i_arst_n;  // async reset, low active
  logic            fsw, gie;  // self-write busy, global irq enable
  logic            req, we, sio, ready, stall, busy, irq, bsplit;
  logic [2:0]      am, rg;
  logic [1:0]      ps;
  logic [5:0]      dp;
  logic [15:0]     addr, ea;
  logic [7:0]      wd, rdata, rd;
  logic [PC_W-1:0] pcmax;
  int              error_cnt = 0;
  int              n_tests = 0;
  int              cyc_cnt = 0;
  mma_top #(.ATOMIC_CYCLES(AT), .SPLIT_CYCLES(SP)) u_mma_top (
    .i_clock, .i_arst_n, .i_req(req), .i_we(we), .i_short_io(sio),
    .i_amode(am), .i_ptr_sel(ps), .i_disp(dp), .i_addr(addr),
    .i_wdata(wd), .i_flash_selfwrite_active(fsw), .i_global_irq_en(gie),
    .o_rdata(rdata), .o_ready(ready), .o_stall(stall), .o_eff_addr(ea),
    .o_region(rg), .o_program_counter_max(pcmax), .o_boot_split(bsplit),
    .o_eeprom_busy(busy), .o_eeprom_ready_irq(irq));
  mma_cpu_model u_mma_cpu_model (
    .i_clock, .i_ready(ready), .i_rdata(rdata), .i_region(rg),
    .i_eff_addr(ea), .o_req(req), .o_we(we), .o_short_io(sio),
    .o_amode(am), .o_ptr_sel(ps), .o_disp(dp), .o_addr(addr),
    .o_wdata(wd));
  wire logic [15:0] sea = u_mma_cpu_model.seen_ea;  // last address seen
  // free-running clock
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, g);
    n_tests++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask
  // bus helpers; every one ends at a falling edge
  task automatic dwr(input logic [15:0] a, input logic [7:0] d);
    u_mma_cpu_model.access(1'b1, 1'b0, AM_DIRECT, 2'h0, 6'h00, a, d, rd);
  endtask
  task automatic drd(input logic [15:0] a, input logic s);
    u_mma_cpu_model.access(1'b0, s, AM_DIRECT, 2'h0, 6'h00, a, 8'h00, rd);
  endtask
  task automatic iowr(input logic [5:0] a, input logic [7:0] d);
    u_mma_cpu_model.access(1'b1, 1'b1, AM_DIRECT, 2'h0, 6'h00,
                           {10'h000, a}, d, rd);
  endtask
  task automatic ptr(input logic [2:0] m, input logic [1:0] p,
                     input logic [5:0] d);
    u_mma_cpu_model.access(1'b0, 1'b0, m, p, d, 16'h0000, 8'h00, rd);
  endtask
  // count falling edges while stall (or busy) stays high
  task automatic count_hi(input logic bsy, output int n);
    n = 0;
    while ((bsy ? busy : stall) === 1'b1 && n < 100) begin
      n++;
      @(negedge i_clock);
    end
  endtask
  task automatic t_const();
    chk("pc max", 16'(FLASH_WORDS - 1), 16'(pcmax));
    chk("boot split", 16'(VARIANT != 0), 16'(bsplit));
  endtask
  // region boundaries, all by direct addressing
  task automatic t_region();
    logic [15:0] ta [9] = '{16'h0000, 16'h001F, 16'h0020, 16'h005F,
      16'h0060, 16'h00FF, 16'h0100, DATA_END - 16'h0001, DATA_END};
    logic [2:0]  tr [9] = '{RG_REGS, RG_REGS, RG_IO, RG_IO, RG_XIO,
      RG_XIO, RG_SRAM, RG_SRAM, RG_NONE};
    for (int i = 0; i < 9; i++) begin
      drd(ta[i], 1'b0);
      chk("region", 16'(tr[i]), 16'(u_mma_cpu_model.seen_rg));
      chk("direct ea", ta[i], sea);
      if (i < 8) begin
        chk("cycles", (tr[i] == RG_SRAM) ? 16'h0002 : 16'h0001,
            16'(u_mma_cpu_model.seen_cyc));
      end
    end
  endtask
  task automatic t_short();
    iowr(6'h1F, 8'h00);
    chk("short ea", 16'h003F, sea);
    drd(16'h0060, 1'b1);
    chk("short xio", 16'(RG_IO), 16'(u_mma_cpu_model.seen_rg));
  endtask
  // a write past the sram end must not alias onto its start
  task automatic t_sram();
    dwr(16'h0100, 8'hA5);
    dwr(DATA_END - 16'h0001, 8'h5A);
    dwr(DATA_END, 8'h3C);
    drd(16'h0100, 1'b0);
    chk("sram low", 16'h00A5, 16'(rd));
    drd(DATA_END - 16'h0001, 1'b0);
    chk("sram top", 16'h005A, 16'(rd));
  endtask
  // X = 0x0110, Y = 0x0200 through the register file
  task automatic t_ptr();
    dwr(16'h001A, 8'h10);
    dwr(16'h001B, 8'h01);
    dwr(16'h001C, 8'h00);
    dwr(16'h001D, 8'h02);
    ptr(AM_IND, 2'h0, 6'h00);
    chk("x ind", 16'h0110, sea);
    ptr(AM_POSTIN, 2'h0, 6'h00);
    chk("x postinc", 16'h0110, sea);
    ptr(AM_IND, 2'h0, 6'h00);
    chk("x after inc", 16'h0111, sea);
    ptr(AM_PREDEC, 2'h0, 6'h00);
    chk("x predec", 16'h0110, sea);
    drd(16'h001A, 1'b0);
    chk("x low reg", 16'h0010, 16'(rd));
    ptr(AM_DISP, 2'h1, 6'h3F);
    chk("y disp", 16'h023F, sea);
  endtask
  // program eeprom byte 0x105, optional arm, gap before strobe
  task automatic ee_prog(input logic [1:0] m, input logic [7:0] d,
    input logic arm, input int gap, output int ns, nb);
    iowr(IOA_EEARL, 8'h05);
    iowr(IOA_EEARH, 8'h01);
    iowr(IOA_EEDR, d);
    if (arm) begin
      iowr(IOA_EECR, {2'h0, m, 4'h4});
    end
    repeat (gap) @(negedge i_clock);
    iowr(IOA_EECR, {2'h0, m, 4'h2});
    count_hi(1'b0, ns);
    count_hi(1'b1, nb);
  endtask
  task automatic ee_rd();
    int ns;
    iowr(IOA_EEDR, 8'h00);
    iowr(IOA_EECR, 8'h01);
    count_hi(1'b0, ns);
    chk("rd stall", 16'h0004, 16'(ns));
    drd({10'h000, IOA_EEDR}, 1'b1);
  endtask
  task automatic t_ee();
    int ns, nb;
    ee_prog(2'h0, 8'h3C, 1'b1, 0, ns, nb);
    chk("wr stall", 16'h0002, 16'(ns));
    chk("atomic", 16'h0001, 16'(nb + 5 >= AT && nb <= AT + 1));
    ee_rd();
    chk("ee data", 16'h003C, 16'(rd));
    ee_prog(2'h1, 8'h00, 1'b1, 0, ns, nb);
    chk("erase", 16'h0001, 16'(nb + 5 >= SP && nb <= SP + 1));
    ee_rd();
    chk("erased", 16'h00FF, 16'(rd));
    ee_prog(2'h2, 8'h5A, 1'b1, 0, ns, nb);
    ee_rd();
    chk("write only", 16'h005A, 16'(rd));
    ee_prog(2'h3, 8'h00, 1'b1, 0, ns, nb);
    chk("mode 11", 16'h0000, 16'(ns + nb));
    ee_prog(2'h0, 8'h00, 1'b0, 0, ns, nb);
    chk("no arm", 16'h0000, 16'(ns + nb));
    ee_prog(2'h0, 8'h00, 1'b1, ARM_CYC + 1, ns, nb);
    chk("late strobe", 16'h0000, 16'(ns + nb));
    ee_rd();
    chk("kept", 16'h005A, 16'(rd));
  endtask
  task automatic t_irq();
    gie = 1'b1;
    iowr(IOA_EECR, 8'h08);
    chk("irq idle", 16'h0001, 16'(irq));
    fsw = 1'b1;
    #1;
    chk("irq selfwrite", 16'h0000, 16'(irq));
    @(negedge i_clock);
    {fsw, gie} = 2'b00;
    #1;
    chk("irq gie", 16'h0000, 16'(irq));
  endtask
  // main sequence
  initial begin
    i_arst_n = 1'b0;
    {fsw, gie} = 2'b00;
    repeat (5) @(negedge i_clock);
    i_arst_n = 1'b1;
    t_const();
    t_region();
    t_short();
    t_sram();
    t_ptr();
    t_ee();
    t_irq();
    end_sim();
  end
  // hang guard
  always @(posedge i_clock) begin
    cyc_cnt++;
    if (cyc_cnt == 5000) begin
      error_cnt++;
      end_sim();
    end
  end
endmodule
